/* File: verilog/vectored_priority_interrupt_unit.v */
// Operation
// - Three levels ranked top, high, low.
// - Refuse requests at or below serviced level.
// - Highest pending level wins arbitration.
// - Equal level: lowest vector address wins.
// - Twenty-seven sources share ten vectors.
// - ext_irq_0 at 00003H, top or low.
// - ext_irq_1 at 0000BH, top or low.
// - Vectors 00013H, 0001BH sources; high or low.
// - Vectors 00023H, 0002BH sources; high or low.
// - Vectors 00033H, 0003BH sources; high or low.
// - Vectors 00043H, 0004BH sources; high or low.
`timescale 1ns/1ps
`default_nettype none
`include "vpiu_map.vh"

module vectored_priority_interrupt_unit (
	input wire ref_clk,
	input wire resetn,
	input wire [7:0] ext_irq,
	input wire [18:0] periph_event,
	input wire [9:0] lvl_sel,
	input wire [26:0] pend_clear,
	input wire irq_ack,
	input wire irq_return,
	output reg irq_req,
	output reg [15:0] irq_vector,
	output reg [1:0] irq_level,
	output reg [26:0] pend_flags,
	output reg [2:0] svc_level
);

// ----------------------------------------
// Functions
// ----------------------------------------
function [1:0] vec_level;
	input [3:0] idx;
	input sel;
	begin
		if (!sel) begin
			vec_level = `LVL_LOW;
		end else if (idx <= `VEC_TOP_LAST) begin
			vec_level = `LVL_TOP;
		end else begin
			vec_level = `LVL_HIGH;
		end
	end
endfunction

function [26:0] vec_mask;
	input [3:0] idx;
	begin
		case (idx)
		4'h0: vec_mask = `VEC0_MASK;
		4'h1: vec_mask = `VEC1_MASK;
		4'h2: vec_mask = `VEC2_MASK;
		4'h3: vec_mask = `VEC3_MASK;
		4'h4: vec_mask = `VEC4_MASK;
		4'h5: vec_mask = `VEC5_MASK;
		4'h6: vec_mask = `VEC6_MASK;
		4'h7: vec_mask = `VEC7_MASK;
		4'h8: vec_mask = `VEC8_MASK;
		4'h9: vec_mask = `VEC9_MASK;
		default: vec_mask = 27'h0000000;
		endcase
	end
endfunction

// Highest in-service level, top first
function [1:0] cur_level;
	input [2:0] svc;
	begin
		if (svc[2]) begin
			cur_level = `LVL_TOP;
		end else if (svc[1]) begin
			cur_level = `LVL_HIGH;
		end else if (svc[0]) begin
			cur_level = `LVL_LOW;
		end else begin
			cur_level = `LVL_NONE;
		end
	end
endfunction

// Lowest set index wins, which is the lower vector address
function [3:0] first_set;
	input [9:0] lvl_word;
	integer k;
	begin
		first_set = 4'h0;
		for (k = `VEC_COUNT - 1; k >= 0; k = k - 1) begin
			if (lvl_word[k]) begin
				first_set = k[3:0];
			end
		end
	end
endfunction

// In-service bit for a level code; the empty level marks nothing
function [2:0] svc_bit;
	input [1:0] lvl;
	begin
		case (lvl)
		`LVL_LOW: svc_bit = 3'h1;
		`LVL_HIGH: svc_bit = 3'h2;
		`LVL_TOP: svc_bit = 3'h4;
		default: svc_bit = 3'h0;
		endcase
	end
endfunction

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Three stages; a change counts only once stages two and three agree
reg [7:0] ext_s1;
reg [7:0] ext_s2;
reg [7:0] ext_s3;
reg [7:0] ext_state;
wire [7:0] ext_stable = ~(ext_s2 ^ ext_s3);
wire [7:0] next_ext_state = (ext_stable & ext_s3) | (~ext_stable & ext_state);
wire [7:0] ext_rise = next_ext_state & ~ext_state;

always @(posedge ref_clk) begin
	if (!resetn) begin
		ext_s1 <= 8'h00;
		ext_s2 <= 8'h00;
		ext_s3 <= 8'h00;
		ext_state <= 8'h00;
	end else begin
		ext_s1 <= ext_irq;
		ext_s2 <= ext_s1;
		ext_s3 <= ext_s2;
		ext_state <= next_ext_state;
	end
end

// ----------------------------------------
// Named source events
// ----------------------------------------
// One name per source keeps the routing checkable against the bit map
wire ev_ext_irq_0 = ext_rise[0];
wire ev_ext_irq_1 = ext_rise[1];
wire ev_ext_irq_2 = ext_rise[2];
wire ev_ext_irq_3 = ext_rise[3];
wire ev_ext_irq_4 = ext_rise[4];
wire ev_ext_irq_5 = ext_rise[5];
wire ev_ext_irq_6 = ext_rise[6];
wire ev_ext_irq_7 = ext_rise[7];
wire ev_timer0_low_half = periph_event[0];
wire ev_base_timer0 = periph_event[1];
wire ev_base_timer1 = periph_event[2];
wire ev_timer0_high_half = periph_event[3];
wire ev_timer1_low_half = periph_event[4];
wire ev_timer1_high_half = periph_event[5];
wire ev_sync_serial_zero = periph_event[6];
wire ev_uart1_rx = periph_event[7];
wire ev_uart2_rx = periph_event[8];
wire ev_sync_serial_one = periph_event[9];
wire ev_uart1_tx = periph_event[10];
wire ev_uart2_tx = periph_event[11];
wire ev_converter = periph_event[12];
wire ev_timer_six = periph_event[13];
wire ev_timer_seven = periph_event[14];
wire ev_port_zero = periph_event[15];
wire ev_timer_four = periph_event[16];
wire ev_timer_five = periph_event[17];
wire ev_pulse_gen_pair = periph_event[18];

// ----------------------------------------
// Source routing into the pending word
// ----------------------------------------
wire [26:0] raw_event = {
	ev_pulse_gen_pair,
	ev_timer_five,
	ev_timer_four,
	ev_port_zero,
	ev_timer_seven,
	ev_timer_six,
	ev_converter,
	ev_uart2_tx,
	ev_uart1_tx,
	ev_sync_serial_one,
	ev_uart2_rx,
	ev_uart1_rx,
	ev_sync_serial_zero,
	ev_ext_irq_7,
	ev_timer1_high_half,
	ev_timer1_low_half,
	ev_ext_irq_6,
	ev_timer0_high_half,
	ev_base_timer1,
	ev_base_timer0,
	ev_ext_irq_5,
	ev_ext_irq_3,
	ev_ext_irq_4,
	ev_timer0_low_half,
	ev_ext_irq_2,
	ev_ext_irq_1,
	ev_ext_irq_0
};

// ----------------------------------------
// Pending flags
// ----------------------------------------
// A set in the clearing cycle wins, so no event is lost
wire [26:0] next_pend = (pend_flags & ~pend_clear) | raw_event;

// ----------------------------------------
// In-service stack and arbitration
// ----------------------------------------
reg [2:0] next_svc;
reg [9:0] vec_pend;
reg [1:0] best_lvl;
reg [3:0] best_idx;
reg [1:0] lvl_i;
reg [1:0] floor_lvl;
reg [9:0] top_vec;
reg [9:0] high_vec;
reg [9:0] low_vec;
reg found;
integer i;

always @* begin
	next_svc = svc_level;
	// Return drops the innermost level before a new entry is taken
	if (irq_return) begin
		if (svc_level[2]) begin
			next_svc[2] = 1'b0;
		end else if (svc_level[1]) begin
			next_svc[1] = 1'b0;
		end else begin
			next_svc[0] = 1'b0;
		end
	end
	if (irq_ack && irq_req) begin
		next_svc = next_svc | svc_bit(irq_level);
	end
end

// Arbitration looks at the next stack so an acked request drops at once
// Each vector lands in the word of its level only if that level may nest
always @* begin
	vec_pend = 10'h000;
	top_vec = 10'h000;
	high_vec = 10'h000;
	low_vec = 10'h000;
	lvl_i = `LVL_NONE;
	floor_lvl = cur_level(next_svc);
	for (i = 0; i < `VEC_COUNT; i = i + 1) begin
		vec_pend[i] = |(next_pend & vec_mask(i[3:0]));
		lvl_i = vec_level(i[3:0], lvl_sel[i]);
		if (vec_pend[i] && lvl_i > floor_lvl) begin
			case (lvl_i)
			`LVL_TOP: begin
				top_vec[i] = 1'b1;
			end
			`LVL_HIGH: begin
				high_vec[i] = 1'b1;
			end
			default: begin
				low_vec[i] = 1'b1;
			end
			endcase
		end
	end
end

// Highest non-empty level first, then the lowest address inside it
always @* begin
	if (|top_vec) begin
		best_lvl = `LVL_TOP;
		best_idx = first_set(top_vec);
		found = 1'b1;
	end else if (|high_vec) begin
		best_lvl = `LVL_HIGH;
		best_idx = first_set(high_vec);
		found = 1'b1;
	end else if (|low_vec) begin
		best_lvl = `LVL_LOW;
		best_idx = first_set(low_vec);
		found = 1'b1;
	end else begin
		best_lvl = `LVL_NONE;
		best_idx = 4'h0;
		found = 1'b0;
	end
end

always @(posedge ref_clk) begin
	if (!resetn) begin
		pend_flags <= `PEND_RESET;
		svc_level <= `SVC_RESET;
		irq_req <= 1'b0;
		irq_vector <= `VEC_BASE;
		irq_level <= `LVL_NONE;
	end else begin
		pend_flags <= next_pend;
		svc_level <= next_svc;
		irq_req <= found;
		irq_vector <= `VEC_BASE + ({12'h000, best_idx} << `VEC_SHIFT);
		irq_level <= best_lvl;
	end
end

endmodule

`default_nettype wire

/* File: verilog/vpiu_map.vh */
`ifndef VPIU_MAP_VH
`define VPIU_MAP_VH

// ----------------------------------------
// Counts
// ----------------------------------------
`define SRC_COUNT 27
`define VEC_COUNT 10
`define EXT_COUNT 8
`define PERIPH_COUNT 19

// ----------------------------------------
// Level codes, higher code wins
// ----------------------------------------
`define LVL_NONE 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_TOP 2'h3

// ----------------------------------------
// Vector addresses: base plus index times eight
// ----------------------------------------
`define VEC_BASE 16'h0003
`define VEC_SHIFT 3
`define VEC_TOP_LAST 4'h1

// ----------------------------------------
// Source masks per vector over the pending word
// ----------------------------------------
`define VEC0_MASK 27'h0000001
`define VEC1_MASK 27'h0000002
`define VEC2_MASK 27'h000001c
`define VEC3_MASK 27'h00001e0
`define VEC4_MASK 27'h0000600
`define VEC5_MASK 27'h0003800
`define VEC6_MASK 27'h001c000
`define VEC7_MASK 27'h00e0000
`define VEC8_MASK 27'h0700000
`define VEC9_MASK 27'h7800000

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PEND_RESET 27'h0000000
`define SVC_RESET 3'h0

`endif

/* File: bench/vpiu_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module vpiu_checker (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic irq_ack,
	input wire logic irq_return,
	input wire logic irq_req,
	input wire logic [18:0] periph_event,
	input wire logic [9:0] lvl_sel,
	input wire logic [26:0] pend_clear,
	input wire logic [26:0] pend_flags,
	input wire logic [15:0] irq_vector,
	input wire logic [1:0] irq_level,
	input wire logic [2:0] svc_level
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		irq_req && irq_ack && !irq_return;
	endsequence
	a_flag_set: assert property (periph_event[0] |=> pend_flags[3]) else $error("no flag");
	a_flag_hold: assert property (pend_flags[3] && !pend_clear[3] |=> pend_flags[3])
		else $error("flag lost");
	a_vec_form: assert property (irq_req |->
		irq_vector[2:0] == 3'h3 && irq_vector < 16'h004c) else $error("bad vector");
	a_top_pair: assert property (irq_req && irq_level == 2'h3 |-> irq_vector < 16'h000c)
		else $error("top misused");
	a_no_nest: assert property (irq_req |->
		irq_level > (svc_level[2] ? 2'h3 : svc_level[1] ? 2'h2 : {1'b0, svc_level[0]}))
		else $error("nested too low");
	a_take_svc: assert property (s_take |=> svc_level[$past(irq_level) - 2'h1])
		else $error("service not marked");
	a_lvl_pick: assert property (irq_req && irq_vector == 16'h0013 |->
		irq_level == ($past(lvl_sel[2]) ? 2'h2 : 2'h1)) else $error("wrong level");
	a_top_wins: assert property (irq_req && pend_flags[0] && svc_level == 3'h0 &&
		$past(lvl_sel[0]) |-> irq_vector == 16'h0003) else $error("wrong winner");
endmodule
bind vectored_priority_interrupt_unit vpiu_checker i_chk (.ref_clk, .resetn, .irq_ack, .irq_return,
	.irq_req, .periph_event, .lvl_sel, .pend_clear, .pend_flags, .irq_vector, .irq_level, .svc_level);
`default_nettype wire

/* File: bench/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Core: takes a standing request after lat cycles, leaves on demand
// ----
module core_model #(parameter int lat = 0) (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic leave,
	input wire logic irq_req,
	output logic irq_ack = 1'h0,
	output logic irq_return = 1'h0
);
	int cnt = 0;
	// Never acks twice in a row: the request drops only on the edge after the ack
	always @(posedge ref_clk) begin
		irq_ack <= 1'h0;
		irq_return <= leave;
		cnt <= 0;
		if (go && irq_req && !irq_ack) begin
			if (cnt == lat)
				irq_ack <= 1'h1;
			else
				cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

/* File: bench/vectored_priority_interrupt_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module vectored_priority_interrupt_unit_test;
	logic ref_clk = 1'h0, resetn = 1'h0, go = 1'h0, leave = 1'h0, irq_ack, irq_return, irq_req;
	logic [7:0] ext_irq = 8'h00;
	logic [18:0] periph_event = 19'h00000;
	logic [9:0] lvl_sel = 10'h000;
	logic [26:0] pend_clear = 27'h0000000, pend_flags;
	logic [15:0] irq_vector;
	logic [1:0] irq_level;
	logic [2:0] svc_level;
	int miscompares = 0, num_checks = 0;
	int pos[27] = '{0, 1, 2, 5, 4, 6, 10, 13, 3, 7, 8, 9, 11, 12, 14, 15, 16, 17, 18, 19, 20, 21,
		22, 23, 24, 25, 26};
	int vi[27] = '{0, 1, 2, 3, 2, 3, 4, 5, 2, 3, 3, 4, 5, 5, 6, 6, 6, 7, 7, 7, 8, 8, 8, 9, 9, 9, 9};
	vectored_priority_interrupt_unit i_dut (.ref_clk, .resetn, .ext_irq, .periph_event, .lvl_sel,
		.pend_clear, .irq_ack, .irq_return, .irq_req, .irq_vector, .irq_level, .pend_flags, .svc_level);
	core_model #(.lat(2)) i_core (.ref_clk, .go, .leave, .irq_req, .irq_ack, .irq_return);
	initial forever #12.5 ref_clk = ~ref_clk;
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task chk(input logic [26:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task clr;
		ext_irq <= 8'h00;
		pend_clear <= 27'h7ffffff;
		tick(1);
		pend_clear <= 27'h0000000;
	endtask
	task t_map;
		lvl_sel <= 10'h3ff;
		for (int i = 0; i < 27; i++) begin
			if (i < 8)
				ext_irq[i] <= 1'h1;
			else
				periph_event[i - 8] <= 1'h1;
			tick(1);
			periph_event <= 19'h00000;
			tick(5);
			#1 chk(pend_flags, 27'h1 << pos[i]);
			chk(irq_vector, 16'h0003 + 16'(8 * vi[i]));
			chk(irq_level, vi[i] < 2 ? 2'h3 : 2'h2);
			tick(1);
			clr;
		end
		$display("map done");
	endtask
	task t_prio;
		lvl_sel <= 10'h000;
		periph_event <= 19'h40009;
		tick(1);
		periph_event <= 19'h00000;
		tick(1);
		#1 chk(irq_vector, 16'h0013);
		tick(1);
		lvl_sel <= 10'h200;
		ext_irq <= 8'h03;
		tick(1);
		#1 chk(irq_vector, 16'h004b);
		tick(1);
		lvl_sel <= 10'h203;
		tick(5);
		#1 chk({irq_vector, irq_level}, {16'h0003, 2'h3});
		tick(1);
		clr;
		$display("prio done");
	endtask
	task t_nest;
		go <= 1'h1;
		periph_event <= 19'h00001;
		tick(1);
		periph_event <= 19'h00000;
		tick(8);
		#1 chk({svc_level, irq_req}, 4'h2);
		tick(1);
		lvl_sel <= 10'h200;
		periph_event <= 19'h40000;
		tick(1);
		periph_event <= 19'h00000;
		tick(8);
		#1 chk(svc_level, 3'h3);
		tick(1);
		go <= 1'h0;
		clr;
		for (int r = 0; r < 2; r++) begin
			leave <= 1'h1;
			tick(1);
			leave <= 1'h0;
			tick(2);
			#1 chk(svc_level, r ? 3'h0 : 3'h1);
			tick(1);
		end
		$display("nest done");
	endtask
	task wrap_up;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		tick(3);
		resetn <= 1'h1;
		tick(1);
		#1 chk({irq_req, svc_level, irq_vector, pend_flags[6:0]}, 27'h0000180);
		tick(1);
		t_map;
		t_prio;
		t_nest;
		wrap_up;
	end
	// About ten times the expected run
	initial begin
		tick(3000);
		miscompares++;
		wrap_up;
	end
endmodule
`default_nettype wire
